// ==== inc/bhac_consts.svh ====
// constants of the backplane host adapter configuration block
`ifndef BHAC_CONSTS_SVH
`define BHAC_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets on the wishbone slave
// ----------------------------------------------------------------
`define BHAC_REG_CTRL 8'h00
`define BHAC_REG_STATUS 8'h04
`define BHAC_REG_SWITCH 8'h08
`define BHAC_REG_DECODE 8'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BHAC_CTRL_IRQ 0
`define BHAC_CTRL_DMA 1
`define BHAC_CTRL_BLOCK 2
`define BHAC_ST_PEND 0
`define BHAC_ST_BUSY 1
`define BHAC_ST_DONE 2
`define BHAC_ST_BLOCK 3
`define BHAC_ST_LEVEL_LO 4
`define BHAC_ST_BURST_LO 8

// ----------------------------------------------------------------
// decode and option values
// ----------------------------------------------------------------
`define BHAC_IO_PAGE_ONES 5'h1F
`define BHAC_BASE_LOW_ZERO 6'h00
`define BHAC_BASE_TOP 3'h7
`define BHAC_WIN_PRIMARY 7'h77
`define BHAC_WIN_SECONDARY 7'h73
`define BHAC_WIN_MIN 16'hE000
`define BHAC_WIN_MAX 16'hFFC0
`define BHAC_BURST_TWO 5'h02
`define BHAC_BURST_FOUR 5'h04
`define BHAC_BURST_BLOCK 5'h10
`define BHAC_LEVEL_BASE 3'h4
`define BHAC_RESET_WORD 32'h00000000

`endif

// ==== inc/bhac_pkg.sv ====
// types of the backplane host adapter configuration block
package bhac_pkg;

  // static option switches, off reads as one
  typedef struct packed {
    logic [3:0] xfer; // transfer/level group: [1:0] level, [2] burst length, [3] block mode
    logic [7:0] vec; // vector group, bit 0 is switch 1
    logic [7:0] addr; // address group, bit 0 is switch 1
  } bhac_switches_t;

  // dma burst sequencer states
  typedef enum logic [1:0] {
    DMA_IDLE,
    DMA_REQ,
    DMA_XFER
  } bhac_dma_state_t;

endpackage

// ==== hdl/bhac_grant_chain.sv ====
// daisy-chained grant: take it when wanted, otherwise pass it on
`timescale 1ns/1ps
`default_nettype none

module bhac_grant_chain (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic grant_in,
  input wire logic want,
  output logic grant_out,
  output logic owned,
  output logic taken
);

  logic prev_q; // grant level one cycle back
  logic owned_q; // grant kept here
  logic pass_q; // grant handed downstream

  // the choice is made once, on the rising grant, and holds until it falls
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= grant_in;
    end
  end

  // ownership versus pass-through
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      owned_q <= 1'b0;
      pass_q <= 1'b0;
    end else if (!grant_in) begin
      owned_q <= 1'b0;
      pass_q <= 1'b0;
    end else if (!prev_q) begin
      owned_q <= want;
      pass_q <= !want;
    end
  end

  assign taken = grant_in && !prev_q && want;
  assign owned = owned_q;
  assign grant_out = pass_q;

endmodule

`default_nettype wire

// ==== hdl/bhac_top.sv ====
// backplane slave decode, interrupt and dma option logic of the adapter
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bhac_consts.svh"

// Notes on behaviour
// - address bits 6-12 match address switches
// - window base low six bits zero
// - address bits 13-17 must be ones
// - base spans 160000 to 177700 octal
// - primary 176700, secondary 176300 selectable
// - vector switches drive vector on acknowledge
// - vector even, within 000 to 374
// - vector bit 1 switch ignored
// - burst two/four words, sixteen in block
// - block mode only with switch four off
// - four levels, defer to higher requests
// - default switches give level four
module bhac_top
  import bhac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire bhac_switches_t option_switches,
  input wire logic [17:0] bus_addr,
  input wire logic bus_addr_strobe,
  output logic window_select,
  input wire logic [3:0] bus_irq_lines,
  output logic [3:0] irq_request_lines,
  input wire logic iak_in,
  output logic iak_out,
  output logic [7:0] vector_out,
  output logic vector_oe,
  output logic dmr_out,
  input wire logic dmg_in,
  output logic dmg_out,
  output logic dma_word_strobe,
  output logic dma_block_mode
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // vector from switches; bits 1 and 0 are never switch driven
  function automatic logic [7:0] vec_of(input logic [7:0] sw);
    vec_of = {sw[7:2], 2'b00};
  endfunction

  // 16-bit window base from the address switches
  function automatic logic [15:0] base_of(input logic [7:0] sw);
    base_of = {`BHAC_BASE_TOP, sw[7:1], `BHAC_BASE_LOW_ZERO};
  endfunction

  // words per burst
  function automatic logic [4:0] burst_of(input logic block, input logic len_off);
    if (block) begin
      burst_of = `BHAC_BURST_BLOCK;
    end else if (len_off) begin
      burst_of = `BHAC_BURST_FOUR;
    end else begin
      burst_of = `BHAC_BURST_TWO;
    end
  endfunction

  // request lines that outrank our own level index
  function automatic logic [3:0] higher_of(input logic [1:0] idx);
    case (idx)
      2'h0: higher_of = 4'hE;
      2'h1: higher_of = 4'hC;
      2'h2: higher_of = 4'h8;
      default: higher_of = 4'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [44:0] sync1_q; // first stage, read only by the second
  logic [44:0] sync2_q; // settled copy
  logic [17:0] s_addr; // synced bus address
  logic s_strobe; // synced address strobe
  logic [3:0] s_irq_lines; // synced request lines, bit i is level 4+i
  logic s_iak; // synced interrupt grant
  logic s_dmg; // synced dma grant
  bhac_switches_t s_sw; // synced option switches

  // every backplane and switch pin crosses two flops before use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= 45'h0;
      sync2_q <= 45'h0;
    end else begin
      sync1_q <= {bus_addr, bus_addr_strobe, bus_irq_lines, iak_in, dmg_in, option_switches};
      sync2_q <= sync1_q;
    end
  end

  assign {s_addr, s_strobe, s_irq_lines, s_iak, s_dmg, s_sw} = sync2_q;

  // ----------------------------------------------------------------
  // register window decode
  // ----------------------------------------------------------------
  logic hit_d; // address falls in the window
  logic window_q; // registered select

  assign hit_d = s_strobe && (s_addr[17:13] == `BHAC_IO_PAGE_ONES)
                 && (s_addr[12:6] == s_sw.addr[7:1]);

  // switch 1 plays no part; the low six bits pick a register inside
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      window_q <= 1'b0;
    end else begin
      window_q <= hit_d;
    end
  end

  assign window_select = window_q;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic ack_q; // one-cycle answer
  logic [31:0] rdata_q; // read data flop
  logic [31:0] rdata_d; // read mux
  logic wr_ctrl; // control write this cycle
  logic wr_status; // status write this cycle
  logic req; // fresh request
  logic irq_pend_q; // interrupt awaiting acknowledge
  logic done_q; // sticky burst done
  logic [4:0] burst_q; // latched words per burst
  logic block_q; // latched block mode
  logic [2:0] level; // interrupt level number

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  // writes land on the acknowledge edge, while the master still holds the request
  assign wr_ctrl = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0]
                   && (wb_adr_i == `BHAC_REG_CTRL);
  assign wr_status = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0]
                     && (wb_adr_i == `BHAC_REG_STATUS);
  assign level = `BHAC_LEVEL_BASE + {1'b0, s_sw.xfer[1:0]};

  // read mux; unmapped offsets answer zero
  always_comb begin
    rdata_d = `BHAC_RESET_WORD;
    case (wb_adr_i)
      `BHAC_REG_STATUS: begin
        rdata_d[`BHAC_ST_PEND] = irq_pend_q;
        rdata_d[`BHAC_ST_BUSY] = dmr_out || dma_word_strobe;
        rdata_d[`BHAC_ST_DONE] = done_q;
        rdata_d[`BHAC_ST_BLOCK] = block_q;
        rdata_d[`BHAC_ST_LEVEL_LO +: 3] = level;
        rdata_d[`BHAC_ST_BURST_LO +: 5] = burst_q;
      end
      `BHAC_REG_SWITCH: begin
        rdata_d[19:0] = s_sw;
      end
      `BHAC_REG_DECODE: begin
        rdata_d[7:0] = vec_of(s_sw.vec);
        rdata_d[31:16] = base_of(s_sw.addr);
      end
      default: begin
        rdata_d = `BHAC_RESET_WORD;
      end
    endcase
  end

  // answer one cycle after the request, then drop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= `BHAC_RESET_WORD;
    end else begin
      ack_q <= req;
      if (req && !wb_we_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ----------------------------------------------------------------
  // interrupt request and acknowledge
  // ----------------------------------------------------------------
  logic higher_busy; // a higher level is requesting
  logic irq_want; // claim the next acknowledge
  logic irq_owned; // acknowledge held here
  logic irq_taken; // acknowledge claimed this cycle
  logic [3:0] irq_lines_q; // request line drive
  logic [7:0] vector_q; // vector drive
  logic iak_pass; // grant passed on

  assign higher_busy = |(s_irq_lines & higher_of(s_sw.xfer[1:0]));
  assign irq_want = irq_pend_q && !higher_busy;

  bhac_grant_chain u_iak_chain (
    .ref_clk(ref_clk),
    .rst(rst),
    .grant_in(s_iak),
    .want(irq_want),
    .grant_out(iak_pass),
    .owned(irq_owned),
    .taken(irq_taken)
  );

  // a software set in the acknowledge cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_pend_q <= 1'b0;
    end else if (wr_ctrl && wb_dat_i[`BHAC_CTRL_IRQ]) begin
      irq_pend_q <= 1'b1;
    end else if (irq_taken) begin
      irq_pend_q <= 1'b0;
    end
  end

  // one-hot request on the selected line
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_lines_q <= 4'h0;
    end else begin
      irq_lines_q <= irq_pend_q ? (4'h1 << s_sw.xfer[1:0]) : 4'h0;
    end
  end

  // vector always tracks the switches; enable marks the drive
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vector_q <= 8'h00;
    end else begin
      vector_q <= vec_of(s_sw.vec);
    end
  end

  assign irq_request_lines = irq_lines_q;
  assign vector_out = vector_q;
  assign vector_oe = irq_owned;
  assign iak_out = iak_pass;

  // ----------------------------------------------------------------
  // dma burst sequencer
  // ----------------------------------------------------------------
  bhac_dma_state_t dma_state_q; // sequencer state
  logic [4:0] cnt_q; // words sent in this burst
  logic dmg_taken; // dma grant claimed
  logic strobe_q; // word strobe flop
  logic start; // software start

  assign start = wr_ctrl && wb_dat_i[`BHAC_CTRL_DMA];

  bhac_grant_chain u_dmg_chain (
    .ref_clk(ref_clk),
    .rst(rst),
    .grant_in(s_dmg),
    .want(dma_state_q == DMA_REQ),
    .grant_out(dmg_out),
    .owned(),
    .taken(dmg_taken)
  );

  // start is ignored while a burst is under way
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dma_state_q <= DMA_IDLE;
      cnt_q <= 5'h00;
    end else begin
      case (dma_state_q)
        DMA_IDLE: begin
          cnt_q <= 5'h00;
          if (start) begin
            dma_state_q <= DMA_REQ;
          end
        end
        DMA_REQ: begin
          if (dmg_taken) begin
            dma_state_q <= DMA_XFER;
          end
        end
        DMA_XFER: begin
          cnt_q <= 5'(cnt_q + 5'h01);
          if (cnt_q == 5'(burst_q - 5'h01)) begin
            dma_state_q <= DMA_IDLE;
          end
        end
        default: begin
          dma_state_q <= DMA_IDLE;
        end
      endcase
    end
  end

  // burst shape is fixed at start so a mid-burst switch change is harmless
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      block_q <= 1'b0;
      burst_q <= `BHAC_BURST_TWO;
    end else if (start && dma_state_q == DMA_IDLE) begin
      block_q <= wb_dat_i[`BHAC_CTRL_BLOCK] && s_sw.xfer[3];
      burst_q <= burst_of(wb_dat_i[`BHAC_CTRL_BLOCK] && s_sw.xfer[3], s_sw.xfer[2]);
    end
  end

  // word strobe drive, registered from the transfer state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= (dma_state_q == DMA_XFER);
    end
  end

  // done: burst end wins over a software clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (dma_state_q == DMA_XFER && cnt_q == 5'(burst_q - 5'h01)) begin
      done_q <= 1'b1;
    end else if (wr_status && wb_dat_i[`BHAC_ST_DONE]) begin
      done_q <= 1'b0;
    end
  end

  assign dmr_out = (dma_state_q == DMA_REQ);
  assign dma_word_strobe = strobe_q;
  assign dma_block_mode = block_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_window_hit: assert property (@(posedge ref_clk) disable iff (rst)
    (s_strobe && &s_addr[17:13] && s_addr[12:6] == s_sw.addr[7:1]) |=> window_select)
    else $error("window select missed a matching address");
  a_window_page: assert property (@(posedge ref_clk) disable iff (rst)
    window_select |-> $past(s_addr[17:13]) == `BHAC_IO_PAGE_ONES)
    else $error("window selected outside the top io page");
  a_window_range: assert property (@(posedge ref_clk) disable iff (rst)
    window_select |-> ($past(s_addr[15:0]) >= `BHAC_WIN_MIN
      && {$past(s_addr[15:6]), 6'h00} <= `BHAC_WIN_MAX
      && base_of(s_sw.addr) == {$past(s_addr[15:6]), 6'h00}))
    else $error("window base out of range");
  a_vector_even: assert property (@(posedge ref_clk) disable iff (rst)
    vector_oe |-> (vector_out[1:0] == 2'b00))
    else $error("vector not even or bit 1 set");
  a_vector_value: assert property (@(posedge ref_clk) disable iff (rst)
    (vector_oe && $stable(s_sw.vec)) |-> vector_out == {s_sw.vec[7:2], 2'b00})
    else $error("vector does not follow the switches");
  a_level_default: assert property (@(posedge ref_clk) disable iff (rst)
    ($past(irq_pend_q) && $past(s_sw.xfer[1:0]) == 2'b00) |-> irq_request_lines == 4'h1)
    else $error("default level is not four");
  a_higher_pass: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(s_iak) && higher_busy) |=> (iak_out && !vector_oe))
    else $error("grant claimed under a higher request");
  a_block_inhibit: assert property (@(posedge ref_clk) disable iff (rst)
    (start && dma_state_q == DMA_IDLE && !s_sw.xfer[3]) |=> !dma_block_mode)
    else $error("block mode used while inhibited");
  a_burst_len: assert property (@(posedge ref_clk) disable iff (rst)
    (dma_state_q == DMA_REQ) |-> burst_q == burst_of(block_q, s_sw.xfer[2]))
    else $error("burst length wrong");
  a_burst_end: assert property (@(posedge ref_clk) disable iff (rst)
    (dma_state_q == DMA_XFER && $past(dma_state_q) == DMA_REQ && burst_q == 5'h02)
      |=> ##1 (dma_state_q == DMA_IDLE) ##1 done_q)
    else $error("two-word burst did not end on time");
  a_ack_single: assert property (@(posedge ref_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  c_primary: cover property (@(posedge ref_clk) disable iff (rst)
    window_select && s_sw.addr[7:1] == `BHAC_WIN_PRIMARY);
  c_secondary: cover property (@(posedge ref_clk) disable iff (rst)
    window_select && s_sw.addr[7:1] == `BHAC_WIN_SECONDARY);
  c_vector: cover property (@(posedge ref_clk) disable iff (rst)
    vector_oe);
  c_block: cover property (@(posedge ref_clk) disable iff (rst)
    dma_block_mode && dma_word_strobe);

endmodule

`default_nettype wire

// ==== dv/bhac_host_model.sv ====
// host side model: address cycles, interrupt grants and dma grants
`timescale 1ns/1ps
`default_nettype none

module bhac_host_model
  import bhac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic other_dmr,
  input wire logic [3:0] other_req,
  input wire logic [3:0] irq_request_lines,
  input wire logic [7:0] vector_out,
  input wire logic vector_oe,
  input wire logic iak_out,
  input wire logic dmr_out,
  input wire logic window_select,
  output logic [3:0] bus_irq_lines,
  output logic iak_in,
  output logic dmg_in,
  output logic [17:0] bus_addr,
  output logic bus_addr_strobe,
  output logic [7:0] got_vec,
  output logic [7:0] vec_cnt,
  output logic [7:0] pass_cnt
);
  // ----
  // state
  // ----
  logic [3:0] irq_wait_q; // rest cycles before the next grant
  logic [3:0] dma_wait_q; // delay before a dma grant

  assign bus_irq_lines = other_req; // requests of other slots

  initial begin
    bus_addr = 18'h00000;
    bus_addr_strobe = 1'b0;
  end

  // one address cycle; released lines show the inverse, not the old value
  task automatic addr_cycle(input logic [17:0] a, output logic sel);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_addr_strobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sel = window_select;
    bus_addr_strobe <= 1'b0;
    bus_addr <= ~a;
    repeat (4) @(posedge ref_clk);
  endtask

  // interrupt grant; the rest period keeps grants apart
  always @(posedge ref_clk) begin
    if (rst) begin
      iak_in <= 1'b0;
      irq_wait_q <= 4'h0;
      got_vec <= 8'h00;
      vec_cnt <= 8'h00;
      pass_cnt <= 8'h00;
    end else if (iak_in) begin
      if (vector_oe === 1'b1) begin // device answered with its vector
        got_vec <= vector_out;
        vec_cnt <= vec_cnt + 8'h01;
        iak_in <= 1'b0;
        irq_wait_q <= 4'h0;
      end else if (iak_out === 1'b1) begin // grant went downstream
        pass_cnt <= pass_cnt + 8'h01;
        iak_in <= 1'b0;
        irq_wait_q <= 4'h0;
      end
    end else if ((|irq_request_lines) || (|other_req)) begin
      irq_wait_q <= irq_wait_q + 4'h1;
      if (irq_wait_q >= (slow ? 4'hE : 4'h8)) begin
        iak_in <= 1'b1;
      end
    end else begin
      irq_wait_q <= 4'h0;
    end
  end

  // dma grant follows the request after a short or long delay
  always @(posedge ref_clk) begin
    if (rst || (dmr_out !== 1'b1 && other_dmr !== 1'b1)) begin
      dmg_in <= 1'b0;
      dma_wait_q <= 4'h0;
    end else begin
      dma_wait_q <= dma_wait_q + 4'h1;
      if (dma_wait_q >= (slow ? 4'h6 : 4'h1)) begin
        dmg_in <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking testbench of the adapter option logic
`timescale 1ns/1ps
`default_nettype none
`include "bhac_consts.svh"

module tb_top;
  import bhac_pkg::*;
  // ----
  // signals
  // ----
  logic ref_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, slow, s, other_dmr;
  logic [7:0] wb_adr, vector_out, got_vec, vec_cnt, pass_cnt, n, p;
  logic [3:0] wb_sel, other_req, bus_irq, irq_lines;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [17:0] bus_addr;
  logic astb, win, iak_in, iak_out, vec_oe, dmr, dmg_in, dmg_out, wstb, blk;
  bhac_switches_t sw;
  int error_cnt, checks_done, stb_cnt, b0, i, k;
  // switch byte, probe address, expected select
  logic [26:0] atab [9] = '{{8'hEF, 18'o776700, 1'b1}, {8'hEF, 18'o776776, 1'b1},
    {8'hEF, 18'o777700, 1'b0}, {8'hEF, 18'o756700, 1'b0}, {8'hEF, 18'o376700, 1'b0},
    {8'hE7, 18'o776300, 1'b1}, {8'h00, 18'o760000, 1'b1}, {8'hFE, 18'o777700, 1'b1},
    {8'hFE, 18'o777600, 1'b0}};
  // vector switches, expected vector
  logic [15:0] vt [4] = '{16'hAFAC, 16'h6968, 16'hFFFC, 16'h0200};
  // xfer[3:2], ctrl block bit, block taken, burst words
  logic [8:0] dt [6] = '{{3'b000, 1'b0, 5'd2}, {3'b010, 1'b0, 5'd4},
    {3'b001, 1'b0, 5'd2}, {3'b101, 1'b1, 5'd16}, {3'b110, 1'b0, 5'd4},
    {3'b111, 1'b1, 5'd16}};

  bhac_top dut_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .option_switches(sw), .bus_addr(bus_addr),
    .bus_addr_strobe(astb), .window_select(win), .bus_irq_lines(bus_irq),
    .irq_request_lines(irq_lines), .iak_in(iak_in), .iak_out(iak_out),
    .vector_out(vector_out), .vector_oe(vec_oe), .dmr_out(dmr), .dmg_in(dmg_in),
    .dmg_out(dmg_out), .dma_word_strobe(wstb), .dma_block_mode(blk));

  bhac_host_model host_u (.ref_clk(ref_clk), .rst(rst), .slow(slow), .other_dmr(other_dmr),
    .other_req(other_req), .irq_request_lines(irq_lines), .vector_out(vector_out),
    .vector_oe(vec_oe), .iak_out(iak_out), .dmr_out(dmr), .window_select(win),
    .bus_irq_lines(bus_irq), .iak_in(iak_in), .dmg_in(dmg_in), .bus_addr(bus_addr),
    .bus_addr_strobe(astb), .got_vec(got_vec), .vec_cnt(vec_cnt), .pass_cnt(pass_cnt));

  // ----
  // clock, word counter, watchdog
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // counts every word strobe the device issues
  always @(posedge ref_clk) begin
    if (wstb === 1'b1) begin
      stb_cnt <= stb_cnt + 1;
    end
  end

  // whole run needs under a thousand cycles
  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end

  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_wdat <= wd;
    @(posedge ref_clk iff wb_ack === 1'b1);
    d = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // new switch setting, then time for the synchronisers
  task automatic set_sw(input bhac_switches_t v);
    @(posedge ref_clk);
    sw <= v;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic conclude();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----
  // tests
  // ----
  initial begin
    {wb_cyc, wb_stb, wb_we, slow, rst} = 5'b00001;
    {wb_adr, wb_sel, wb_wdat, other_req, other_dmr} = '0;
    sw = '{xfer: 4'h0, vec: 8'hAF, addr: 8'hEF};
    {error_cnt, checks_done, stb_cnt} = '0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    wb(1'b0, `BHAC_REG_STATUS, 32'h0, rd);
    chk(rd, 32'h00000240);
    wb(1'b0, `BHAC_REG_DECODE, 32'h0, rd);
    chk(rd, 32'hFDC000AC);
    wb(1'b0, `BHAC_REG_SWITCH, 32'h0, rd);
    chk(rd, {12'h000, sw});
    wb(1'b1, 8'h10, 32'hFFFFFFFF, rd);
    wb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    // window decode over the switch table
    for (i = 0; i < 9; i++) begin
      set_sw({4'h0, 8'hAF, atab[i][26:19]});
      host_u.addr_cycle(atab[i][18:1], s);
      chk({31'h0, s}, {31'h0, atab[i][0]});
    end
    // every level, vector taken on acknowledge
    for (i = 0; i < 4; i++) begin
      slow <= i[0];
      set_sw({2'b00, i[1:0], vt[i][15:8], 8'hEF});
      wb(1'b0, `BHAC_REG_DECODE, 32'h0, rd);
      chk({24'h0, rd[7:0]}, {24'h0, vt[i][7:0]});
      wb(1'b0, `BHAC_REG_STATUS, 32'h0, rd);
      chk({29'h0, rd[6:4]}, 32'h4 + i);
      n = vec_cnt;
      wb(1'b1, `BHAC_REG_CTRL, 32'h1, rd);
      repeat (3) @(posedge ref_clk);
      chk({28'h0, irq_lines}, 32'h1 << i);
      for (k = 0; k < 100 && vec_cnt == n; k++) @(posedge ref_clk);
      chk({24'h0, got_vec}, {24'h0, vt[i][7:0]});
    end
    // higher request active: grant must pass on
    set_sw('{xfer: 4'h0, vec: 8'hAF, addr: 8'hEF});
    other_req <= 4'h8;
    repeat (4) @(posedge ref_clk);
    n = vec_cnt;
    wb(1'b1, `BHAC_REG_CTRL, 32'h1, rd);
    p = pass_cnt;
    for (k = 0; k < 100 && pass_cnt == p; k++) @(posedge ref_clk);
    chk({31'h0, pass_cnt != p}, 32'h1);
    chk({24'h0, vec_cnt}, {24'h0, n});
    other_req <= 4'h0;
    for (k = 0; k < 100 && vec_cnt == n; k++) @(posedge ref_clk);
    chk({24'h0, vec_cnt}, {24'h0, n + 8'h01});
    // dma grant while idle must go on down the chain, then fall with it
    other_dmr <= 1'b1;
    for (k = 0; k < 20 && dmg_out !== 1'b1; k++) @(posedge ref_clk);
    chk({31'h0, dmg_out}, 32'h1);
    other_dmr <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({31'h0, dmg_out}, 32'h0);
    // burst lengths and block mode
    for (i = 0; i < 6; i++) begin
      slow <= i[0];
      set_sw({dt[i][8:7], 2'b00, 8'hAF, 8'hEF});
      b0 = stb_cnt;
      wb(1'b1, `BHAC_REG_CTRL, {29'h0, dt[i][6], 2'b10}, rd);
      rd = 32'h0;
      for (k = 0; k < 40 && rd[2] !== 1'b1; k++) wb(1'b0, `BHAC_REG_STATUS, 32'h0, rd);
      // the last word strobe may still show as busy when done first reads set
      wb(1'b0, `BHAC_REG_STATUS, 32'h0, rd);
      chk(rd, {19'h0, dt[i][4:0], 4'h4, dt[i][5], 3'b100});
      chk(stb_cnt - b0, {27'h0, dt[i][4:0]});
      chk({31'h0, blk}, {31'h0, dt[i][5]});
      wb(1'b1, `BHAC_REG_STATUS, 32'h4, rd);
      wb(1'b0, `BHAC_REG_STATUS, 32'h0, rd);
      chk({31'h0, rd[2]}, 32'h0);
    end
    conclude();
  end
endmodule

`default_nettype wire
